// [pkg/aio_image_map.vh]
// Constants for the analog I/O image block.
// Assumes inclusion by bare name from design files.
`ifndef AIO_IMAGE_MAP_VH
`define AIO_IMAGE_MAP_VH
// ----------------------------------------
// Validity encoding
// ----------------------------------------
`define VALID_FLAG       1'b0
`define INVALID_FLAG     1'b1
// ----------------------------------------
// Operating modes
// ----------------------------------------
`define MODE_IDLE        3'h1
`define MODE_READY       3'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define OUT_TIMEOUT_DEF  32'h0000_FFFF
`define TX_PERIOD_DEF    32'h0000_1000
`endif

// [design/aio_table_mem.v]
// Small word table with registered read data.
// Assumes one clock; one write and one read port.
`default_nettype none
module aio_table_mem #(
    parameter WIDTH = 16,
    parameter AW    = 5
) (
    // Clock
    input  wire             clk_i,
    // Write port
    input  wire             we_i,
    input  wire [AW-1:0]    waddr_i,
    input  wire [WIDTH-1:0] wdata_i,
    // Read port
    input  wire [AW-1:0]    raddr_i,
    output reg  [WIDTH-1:0] rdata_o
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Write then registered read
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule
`default_nettype wire

// [design/aio_image.v]
// Analog I/O image: input/output tables, forcing, validity, fault contacts.
// Assumes nest and network strobes are synchronous to sys_clk_i.
`include "aio_image_map.vh"
`default_nettype none
// Operation
// - Keep input value, validity, forced value, forced validity tables.
// - Keep output value, validity, forced value, forced validity tables.
// - Input scan reads every module and stores words into input table.
// - Module fault: default or hold inputs, mark them invalid.
// - Forced input point shows forced value; others keep scanned values.
// - Released force shows the last scanned value at once.
// - Processed value keeps updating while point is forced.
// - Forcing a point forces its validity flag to valid.
// - Pack input values into comm variables, transmit periodically.
// - Answer input requests even while data is invalid.
// - Store received output values into output value table.
// - Examine received qualifiers before using output values.
// - No output data within timeout marks outputs invalid.
// - Invalid output drives default or held value per point config.
// - Keep status for every module in the nest.
// - On fault, log it and activate the module fault contact.
// - Fault contact active only while fault persists.
// - Cleared fault deactivates contact and resumes normal operation.
// - Accept force requests only in idle or ready mode.
// - Output scan runs after input scan completes.
module aio_image #(
    parameter NMOD         = 8,
    parameter PPM          = 4,
    parameter AW           = 5,
    parameter OUT_TIMEOUT  = `OUT_TIMEOUT_DEF,
    parameter TX_PERIOD    = `TX_PERIOD_DEF
) (
    // Clock and reset
    input  wire                  sys_clk_i,
    input  wire                  rstn_i,
    // Mode and cycle control
    input  wire [2:0]            mode_i,
    input  wire                  cycle_start_i,
    // Nest input read
    output reg                   nest_rd_o,
    output reg  [AW-1:0]         nest_addr_o,
    input  wire [15:0]           nest_rdata_i,
    input  wire                  nest_rvalid_i,
    input  wire [NMOD-1:0]       mod_fault_i,
    // Per-point configuration
    input  wire [(1<<AW)-1:0]    in_hold_cfg_i,
    input  wire [15:0]           in_default_i,
    input  wire [(1<<AW)-1:0]    out_hold_cfg_i,
    input  wire [15:0]           out_default_i,
    // Nest output write
    output reg                   nest_wr_o,
    output reg  [AW-1:0]         nest_waddr_o,
    output reg  [15:0]           nest_wdata_o,
    // Force requests
    input  wire                  force_we_i,
    input  wire                  force_out_i,
    input  wire                  force_set_i,
    input  wire [AW-1:0]         force_addr_i,
    input  wire [15:0]           force_value_i,
    output wire                  force_ack_o,
    // Received output variables
    input  wire                  rx_we_i,
    input  wire [AW-1:0]         rx_addr_i,
    input  wire [15:0]           rx_value_i,
    input  wire                  rx_qual_i,
    input  wire                  rx_frame_i,
    // Transmitted input variables
    output reg                   tx_start_o,
    input  wire                  tx_rd_i,
    input  wire [AW-1:0]         tx_addr_i,
    output wire [15:0]           tx_value_o,
    output reg                   tx_valid_flag_o,
    // Diagnostics
    output reg  [NMOD-1:0]       fault_contact_o,
    output reg  [NMOD-1:0]       fault_log_o,
    output wire [NMOD-1:0]       mod_status_o,
    output wire                  cycle_done_o
);
    localparam NPT = 1 << AW;
    // Scan states, one-hot
    localparam S_IDLE = 4'b0001;
    localparam S_IN   = 4'b0010;
    localparam S_OUT  = 4'b0100;
    localparam S_DONE = 4'b1000;

    // ----------------------------------------
    // Flags and force tables
    // ----------------------------------------
    reg [NPT-1:0]  analog_in_validity;
    reg [NPT-1:0]  analog_in_forced_validity;
    reg [NPT-1:0]  in_force_reg;
    reg [NPT-1:0]  analog_out_validity;
    reg [NPT-1:0]  analog_out_forced_validity;
    reg [NPT-1:0]  out_force_reg;
    reg [3:0]      state_reg;
    reg [AW-1:0]   idx_reg;
    reg            pend_reg;
    reg [31:0]     tmo_reg;
    reg [31:0]     tx_cnt_reg;
    reg            tx_rd_reg;
    reg [AW-1:0]   tx_addr_reg;
    reg [AW-1:0]   out_idx_d_reg;
    reg            out_rd_d_reg;
    reg            in_ok_reg;
    reg [15:0]     in_word_reg;

    wire           force_ok = (mode_i == `MODE_IDLE) || (mode_i == `MODE_READY);
    wire [31:0]    mod_idx  = idx_reg / PPM;
    wire           cur_flt  = mod_fault_i[mod_idx[$clog2(NMOD)-1:0]];

    assign force_ack_o = force_we_i & force_ok;
    assign cycle_done_o = (state_reg == S_DONE);
    assign mod_status_o = fault_contact_o;

    // ----------------------------------------
    // Tables
    // ----------------------------------------
    // input value tables
    wire [15:0] in_val_rd;
    wire [15:0] in_frc_rd;
    wire        pend_take = (state_reg == S_IN) && !pend_reg && (nest_rvalid_i || cur_flt);
    wire [15:0] in_scan_word = in_ok_reg ? in_word_reg :
                               (in_hold_cfg_i[idx_reg] ? in_val_rd : in_default_i);
    wire        in_we = (state_reg == S_IN) && pend_reg;
    aio_table_mem #(.WIDTH(16), .AW(AW)) analog_in_values (
        .clk_i   (sys_clk_i),
        .we_i    (in_we),
        .waddr_i (idx_reg),
        .wdata_i (in_scan_word),
        .raddr_i ((in_we || pend_take) ? idx_reg : (tx_rd_i ? tx_addr_i : idx_reg)),
        .rdata_o (in_val_rd)
    );
    wire        in_frc_we = force_ack_o && !force_out_i && force_set_i;
    aio_table_mem #(.WIDTH(16), .AW(AW)) analog_in_forced_values (
        .clk_i   (sys_clk_i),
        .we_i    (in_frc_we),
        .waddr_i (force_addr_i),
        .wdata_i (force_value_i),
        .raddr_i (tx_addr_i),
        .rdata_o (in_frc_rd)
    );
    assign tx_value_o = in_force_reg[tx_addr_reg] ? in_frc_rd : in_val_rd;

    wire [15:0] out_val_rd;
    wire [15:0] out_frc_rd;
    aio_table_mem #(.WIDTH(16), .AW(AW)) analog_out_values (
        .clk_i   (sys_clk_i),
        .we_i    (rx_we_i),
        .waddr_i (rx_addr_i),
        .wdata_i (rx_value_i),
        .raddr_i (idx_reg),
        .rdata_o (out_val_rd)
    );
    wire        out_frc_we = force_ack_o && force_out_i && force_set_i;
    aio_table_mem #(.WIDTH(16), .AW(AW)) analog_out_forced_values (
        .clk_i   (sys_clk_i),
        .we_i    (out_frc_we),
        .waddr_i (force_addr_i),
        .wdata_i (force_value_i),
        .raddr_i (idx_reg),
        .rdata_o (out_frc_rd)
    );

    // ----------------------------------------
    // Scan sequencer
    // ----------------------------------------
    // output after input
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg  <= S_IDLE;
            idx_reg    <= {AW{1'b0}};
            pend_reg   <= 1'b0;
            nest_rd_o  <= 1'b0;
            nest_addr_o <= {AW{1'b0}};
        end else begin
            nest_rd_o <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (cycle_start_i) begin
                        state_reg   <= S_IN;
                        idx_reg     <= {AW{1'b0}};
                        nest_rd_o   <= 1'b1;
                        nest_addr_o <= {AW{1'b0}};
                        pend_reg    <= 1'b0;
                    end
                end
                S_IN: begin
                    if (!pend_reg) begin
                        if (nest_rvalid_i || cur_flt) begin
                            pend_reg <= 1'b1;
                        end
                    end else begin
                        pend_reg <= 1'b0;
                        if (idx_reg == NPT - 1) begin
                            state_reg <= S_OUT;
                            idx_reg   <= {AW{1'b0}};
                        end else begin
                            idx_reg     <= idx_reg + 1'b1;
                            nest_rd_o   <= 1'b1;
                            nest_addr_o <= idx_reg + 1'b1;
                        end
                    end
                end
                S_OUT: begin
                    if (idx_reg == NPT - 1) begin
                        state_reg <= S_DONE;
                    end else begin
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                S_DONE: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Input validity and forcing
    // ----------------------------------------
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            analog_in_validity        <= {NPT{`INVALID_FLAG}};
            analog_in_forced_validity <= {NPT{`INVALID_FLAG}};
            in_force_reg              <= {NPT{1'b0}};
            in_ok_reg                 <= 1'b0;
            in_word_reg               <= 16'h0000;
        end else begin
            if (pend_take) begin
                analog_in_validity[idx_reg] <= cur_flt ? `INVALID_FLAG : `VALID_FLAG;
                in_ok_reg                   <= nest_rvalid_i && !cur_flt;
                in_word_reg                 <= nest_rdata_i;
            end
            if (force_ack_o && !force_out_i) begin
                in_force_reg[force_addr_i]              <= force_set_i;
                analog_in_forced_validity[force_addr_i] <= `VALID_FLAG;
            end
        end
    end

    // Validity flag returned beside transmitted value
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_rd_reg       <= 1'b0;
            tx_addr_reg     <= {AW{1'b0}};
            tx_valid_flag_o <= `INVALID_FLAG;
        end else begin
            tx_rd_reg   <= tx_rd_i;
            tx_addr_reg <= tx_addr_i;
            if (tx_rd_i) begin
                tx_valid_flag_o <= in_force_reg[tx_addr_i] ?
                                   analog_in_forced_validity[tx_addr_i] :
                                   analog_in_validity[tx_addr_i];
            end
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_cnt_reg <= 32'h0000_0000;
            tx_start_o <= 1'b0;
        end else begin
            tx_start_o <= (tx_cnt_reg == TX_PERIOD - 1);
            tx_cnt_reg <= (tx_cnt_reg == TX_PERIOD - 1) ? 32'h0000_0000 : tx_cnt_reg + 1'b1;
        end
    end

    // ----------------------------------------
    // Output validity, timeout and drive
    // ----------------------------------------
    // timeout restart
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tmo_reg                    <= 32'h0000_0000;
            analog_out_validity        <= {NPT{`INVALID_FLAG}};
            analog_out_forced_validity <= {NPT{`INVALID_FLAG}};
            out_force_reg              <= {NPT{1'b0}};
        end else begin
            if (rx_frame_i) begin
                tmo_reg <= 32'h0000_0000;
            end else if (tmo_reg != OUT_TIMEOUT) begin
                tmo_reg <= tmo_reg + 1'b1;
            end
            if (!rx_frame_i && tmo_reg == OUT_TIMEOUT - 1) begin
                analog_out_validity <= {NPT{`INVALID_FLAG}};
            end
            if (rx_we_i) begin
                analog_out_validity[rx_addr_i] <= rx_qual_i;
            end
            if (force_ack_o && force_out_i) begin
                out_force_reg[force_addr_i]              <= force_set_i;
                analog_out_forced_validity[force_addr_i] <= `VALID_FLAG;
            end
        end
    end

    // Delay tracking for registered table reads
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_rd_d_reg  <= 1'b0;
            out_idx_d_reg <= {AW{1'b0}};
        end else begin
            out_rd_d_reg  <= (state_reg == S_OUT);
            out_idx_d_reg <= idx_reg;
        end
    end

    reg [15:0] held_reg [0:NPT-1];
    wire [15:0] out_norm = (analog_out_validity[out_idx_d_reg] == `VALID_FLAG) ? out_val_rd :
                           (out_hold_cfg_i[out_idx_d_reg] ? held_reg[out_idx_d_reg] :
                            out_default_i);
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nest_wr_o    <= 1'b0;
            nest_waddr_o <= {AW{1'b0}};
            nest_wdata_o <= 16'h0000;
        end else begin
            nest_wr_o    <= out_rd_d_reg;
            nest_waddr_o <= out_idx_d_reg;
            nest_wdata_o <= out_force_reg[out_idx_d_reg] ? out_frc_rd : out_norm;
        end
    end
    always @(posedge sys_clk_i) begin
        if (out_rd_d_reg && !out_force_reg[out_idx_d_reg]) begin
            held_reg[out_idx_d_reg] <= out_norm;
        end
    end

    // ----------------------------------------
    // Diagnostics
    // ----------------------------------------
    // per-module status
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_contact_o <= {NMOD{1'b0}};
            fault_log_o     <= {NMOD{1'b0}};
        end else begin
            fault_contact_o <= mod_fault_i;
            fault_log_o     <= fault_log_o | mod_fault_i;
        end
    end
endmodule
`default_nettype wire

// [tb/nest_model.sv]
// I/O nest model: answers point reads, records output writes.
// Assumes the image block's nest strobes are on sys_clk_i.
`default_nettype none
module nest_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    // Bench setup
    input  wire logic [3:0]  lat_i,
    input  wire logic [15:0] base_i,
    // Nest bus
    input  wire logic        rd_i,
    input  wire logic [4:0]  addr_i,
    output logic             rvalid_o,
    output logic [15:0]      rdata_o,
    input  wire logic        wr_i,
    input  wire logic [4:0]  waddr_i,
    input  wire logic [15:0] wdata_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] out_mem [0:31];
    logic [3:0]  wait_cnt;
    logic [4:0]  addr_q;
    logic        busy;
    // answer each read lat_i+1 cycles after it is sampled; idle data toggles
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            busy <= 1'b1;
            wait_cnt <= lat_i;
            addr_q <= addr_i;
            rvalid_o <= 1'b0;
        end else if (busy && wait_cnt == 4'h0) begin
            busy <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= base_i ^ {11'h000, addr_q};
        end else begin
            wait_cnt <= wait_cnt - 4'h1;
            rvalid_o <= 1'b0;
            rdata_o <= ~rdata_o;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (wr_i) out_mem[waddr_i] <= wdata_i;
    end
endmodule
`default_nettype wire

// [tb/aio_image_sva.sv]
// Port checker for the analog I/O image block.
// Assumes binding to aio_image; one clock domain.
`default_nettype none
module aio_image_sva #(
    parameter NMOD = 8,
    parameter AW = 5,
    parameter TX_PERIOD = 16
) (
    input wire logic            sys_clk_i,
    input wire logic            rstn_i,
    input wire logic [2:0]      mode_i,
    input wire logic            force_we_i,
    input wire logic            force_ack_o,
    input wire logic [NMOD-1:0] mod_fault_i,
    input wire logic [NMOD-1:0] fault_contact_o,
    input wire logic [NMOD-1:0] fault_log_o,
    input wire logic [NMOD-1:0] mod_status_o,
    input wire logic            nest_rd_o,
    input wire logic [AW-1:0]   nest_addr_o,
    input wire logic            nest_wr_o,
    input wire logic            tx_start_o,
    input wire logic            cycle_start_i,
    input wire logic            cycle_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    int unsigned tx_gap;
    logic        tx_seen;
    logic        out_phase;
    // Spacing of transmit starts and output phase tracking
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_gap <= 0;
            tx_seen <= 1'b0;
            out_phase <= 1'b0;
        end else begin
            tx_gap <= tx_start_o ? 1 : tx_gap + 1;
            if (tx_start_o) tx_seen <= 1'b1;
            if (cycle_start_i) out_phase <= 1'b0;
            else if (nest_wr_o) out_phase <= 1'b1;
        end
    end
    sequence rd_once;
        nest_rd_o ##1 !nest_rd_o;
    endsequence
    force_gate_a: assert property (
        force_ack_o == (force_we_i && (mode_i == 3'h1 || mode_i == 3'h2)))
        else $error("force ack wrong for mode");
    contact_follow_a: assert property (
        fault_contact_o == $past(mod_fault_i)) else $error("fault contact not tracking");
    contact_release_a: assert property (
        $fell(mod_fault_i[0]) |=> !fault_contact_o[0]) else $error("contact stuck");
    status_keep_a: assert property (
        mod_status_o == fault_contact_o) else $error("module status differs");
    log_sticky_a: assert property (
        (fault_log_o & $past(fault_log_o)) == $past(fault_log_o)) else $error("log lost");
    read_pulse_a: assert property (
        nest_rd_o |-> rd_once) else $error("read strobe too long");
    read_addr_a: assert property (
        nest_rd_o |=> $stable(nest_addr_o)) else $error("read address moved");
    tx_spacing_a: assert property (
        (tx_start_o && tx_seen) |-> tx_gap == TX_PERIOD) else $error("tx period wrong");
    out_after_in_a: assert property (
        out_phase |-> !nest_rd_o) else $error("read during output scan");
    done_pulse_a: assert property (
        cycle_done_o |=> !cycle_done_o) else $error("cycle done held too long");
endmodule
bind aio_image aio_image_sva #(.NMOD(NMOD), .AW(AW), .TX_PERIOD(TX_PERIOD)) aio_image_sva_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .mode_i(mode_i), .force_we_i(force_we_i),
    .force_ack_o(force_ack_o), .mod_fault_i(mod_fault_i), .fault_contact_o(fault_contact_o),
    .fault_log_o(fault_log_o), .mod_status_o(mod_status_o), .nest_rd_o(nest_rd_o),
    .nest_addr_o(nest_addr_o), .nest_wr_o(nest_wr_o), .tx_start_o(tx_start_o),
    .cycle_done_o(cycle_done_o), .cycle_start_i(cycle_start_i));
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for the analog I/O image block.
// Assumes the nest model and the bound checker are compiled first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rstn, cs, rvl, rd, wr, fwe, fo, fs, fack, rwe, rq, rfr, txs, trd, tvf, done;
    logic [2:0] mode;
    logic [3:0] lat;
    logic [4:0] na, nwa, fa, ra, ta;
    logic [7:0] mf, fc, fl, ms;
    logic [15:0] base, nrd, nwd, fv, rv, tv, idf, odf, v;
    logic [31:0] ihc, ohc;
    logic f;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    aio_image #(.OUT_TIMEOUT(1000), .TX_PERIOD(16)) aio_image_i (
        .sys_clk_i(clk), .rstn_i(rstn), .mode_i(mode), .cycle_start_i(cs), .nest_rd_o(rd),
        .nest_addr_o(na), .nest_rdata_i(nrd), .nest_rvalid_i(rvl), .mod_fault_i(mf),
        .in_hold_cfg_i(ihc), .in_default_i(idf), .out_hold_cfg_i(ohc), .out_default_i(odf),
        .nest_wr_o(wr), .nest_waddr_o(nwa), .nest_wdata_o(nwd), .force_we_i(fwe),
        .force_out_i(fo), .force_set_i(fs), .force_addr_i(fa), .force_value_i(fv),
        .force_ack_o(fack), .rx_we_i(rwe), .rx_addr_i(ra), .rx_value_i(rv), .rx_qual_i(rq),
        .rx_frame_i(rfr), .tx_start_o(txs), .tx_rd_i(trd), .tx_addr_i(ta), .tx_value_o(tv),
        .tx_valid_flag_o(tvf), .fault_contact_o(fc), .fault_log_o(fl), .mod_status_o(ms),
        .cycle_done_o(done));
    nest_model nest_model_i (.sys_clk_i(clk), .rstn_i(rstn), .lat_i(lat), .base_i(base),
        .rd_i(rd), .addr_i(na), .rvalid_o(rvl), .rdata_o(nrd), .wr_i(wr), .waddr_i(nwa),
        .wdata_i(nwd));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic scan();
        int k;
        k = 0;
        @(posedge clk) cs <= 1'b1;
        @(posedge clk) cs <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (done !== 1'b1 && k < 3000);
        if (k == 3000) chk(16'h0000, 16'h0001);
        repeat (3) @(posedge clk);
    endtask
    task automatic rdtx(input logic [4:0] a);
        @(posedge clk) begin
            trd <= 1'b1;
            ta <= a;
        end
        @(posedge clk) trd <= 1'b0;
        #1 v = tv;
        f = tvf;
    endtask
    task automatic frc(input logic o, input logic s, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk) begin
            fwe <= 1'b1; fo <= o; fs <= s; fa <= a; fv <= d;
        end
        #1 f = fack;
        @(posedge clk) fwe <= 1'b0;
    endtask
    task automatic rx(input logic [4:0] a, input logic [15:0] d, input logic q);
        @(posedge clk) begin
            rwe <= 1'b1; rfr <= 1'b1; ra <= a; rv <= d; rq <= q;
        end
        @(posedge clk) begin
            rwe <= 1'b0;
            rfr <= 1'b0;
        end
    endtask
    task automatic t_fault();
        idf <= 16'h0BAD; ihc <= 32'h0000_0F00; mf <= 8'h06; base <= 16'hD000; lat <= 4'h3;
        scan();
        chk({8'h00, fc}, 16'h0006);
        chk({8'h00, ms}, 16'h0006);
        rdtx(5'd4); chk(v, 16'h0BAD); chk({15'h0, f}, 16'h0001);
        rdtx(5'd9); chk(v, 16'hC009); chk({15'h0, f}, 16'h0001);
        rdtx(5'd0); chk(v, 16'hD000); chk({15'h0, f}, 16'h0000);
        mf <= 8'h00;
        scan();
        rdtx(5'd4); chk(v, 16'hD004); chk({15'h0, f}, 16'h0000);
        chk({8'h00, fc}, 16'h0000);
        chk({8'h00, fl}, 16'h0006);
        $display("t_fault done");
    endtask
    task automatic t_force();
        mode <= 3'h3; frc(1'b0, 1'b1, 5'd1, 16'h0777); chk({15'h0, f}, 16'h0000);
        mode <= 3'h1; frc(1'b0, 1'b1, 5'd2, 16'h01F4); chk({15'h0, f}, 16'h0001);
        mode <= 3'h2; frc(1'b0, 1'b1, 5'd30, 16'h0500); chk({15'h0, f}, 16'h0001);
        mf <= 8'h01;
        scan();
        rdtx(5'd2); chk(v, 16'h01F4); chk({15'h0, f}, 16'h0000);
        rdtx(5'd1); chk(v, 16'h0BAD);
        rdtx(5'd30); chk(v, 16'h0500);
        rdtx(5'd31); chk(v, 16'hD01F);
        mf <= 8'h00; base <= 16'hE000; lat <= 4'h0;
        frc(1'b0, 1'b0, 5'd2, 16'h0000);
        scan();
        rdtx(5'd2); chk(v, 16'hE002); chk({15'h0, f}, 16'h0000);
        $display("t_force done");
    endtask
    task automatic t_out();
        odf <= 16'h0DEF; ohc <= 32'h0000_0080;
        rx(5'd5, 16'h0072, 1'b0); rx(5'd6, 16'h0048, 1'b1); rx(5'd7, 16'h006A, 1'b0);
        scan();
        chk(nest_model_i.out_mem[5], 16'h0072);
        chk(nest_model_i.out_mem[6], 16'h0DEF);
        chk(nest_model_i.out_mem[7], 16'h006A);
        rx(5'd7, 16'h0011, 1'b1); frc(1'b1, 1'b1, 5'd5, 16'h1234);
        scan();
        chk(nest_model_i.out_mem[7], 16'h006A);
        chk(nest_model_i.out_mem[5], 16'h1234);
        rx(5'd5, 16'h005D, 1'b0); frc(1'b1, 1'b0, 5'd5, 16'h0000);
        scan();
        chk(nest_model_i.out_mem[5], 16'h005D);
        $display("t_out done");
    endtask
    task automatic t_tmo();
        rx(5'd9, 16'h0042, 1'b0);
        repeat (600) @(posedge clk);
        rx(5'd10, 16'h0043, 1'b0);
        repeat (600) @(posedge clk);
        scan();
        chk(nest_model_i.out_mem[9], 16'h0042);
        repeat (1100) @(posedge clk);
        scan();
        chk(nest_model_i.out_mem[9], 16'h0DEF);
        chk(nest_model_i.out_mem[10], 16'h0DEF);
        $display("t_tmo done");
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Reset, then the scenarios
    initial begin
        {rstn, cs, fwe, fo, fs, rwe, rq, rfr, trd} = '0;
        {fa, ra, ta, fv, rv, mf, idf, odf, ihc, ohc} = '0;
        mode = 3'h1; lat = 4'h0; base = 16'hC000;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        scan();
        rdtx(5'd13); chk(v, 16'hC00D); chk({15'h0, f}, 16'h0000);
        rdtx(5'd31); chk(v, 16'hC01F);
        $display("t_scan done");
        t_fault();
        t_force();
        t_out();
        t_tmo();
        conclude();
    end
endmodule
`default_nettype wire
